//--- rtl/fan_ctrl_pkg.sv
// Purpose: Shared constants and types for the fan ramp and floor duty block
// Assumes: 40 MHz core clock, 8-bit register port
// Notes on behaviour
// [RULE1] Remote 2 duty moves stepwise toward target when its smoothing is on
// [RULE2] Fast table: codes add 1,2,3,4,8,12,24,48 per slot; 37.5 s to 0.8 s
// [RULE3] Slow table: same codes sweep in 52.2 s down to 1.1 s
// [RULE4] Local channel smoothing only while acoustics bit 3 is set
// [RULE5] Remote 2 smoothing only while bit 7 set; its code in bits 6:4
// [RULE6] Lock set makes acoustics register ignore all writes
// [RULE7] Floor duty register sets output floor; 0x00 off, 0xff full
// [RULE8] Floor duty registers at 0x64..0x66 reset to 0x80
// [RULE9] Automatic mode makes floor duty registers reject writes
// [RULE10] Above start temperature run at floor, rising with temperature span
// [RULE11] Start temperatures at 0x67..0x69 reset to 0x5a
// [RULE12] Local ramp code sits in acoustics bits 2:0, same tables
// [RULE13] Below start minus hysteresis: off, or floor if select bit set
// [RULE14] High time is code/256 of period; 0xff is fully on
// [RULE15] One step per slot, never overshooting the target
package fan_ctrl_pkg;
   // Register offsets
   localparam logic [7:0] ACOUSTIC_OFS = 8'h63;
   localparam logic [7:0] MIN_DUTY1_OFS = 8'h64;
   localparam logic [7:0] MIN_DUTY2_OFS = 8'h65;
   localparam logic [7:0] MIN_DUTY3_OFS = 8'h66;
   localparam logic [7:0] START_R1_OFS = 8'h67;
   localparam logic [7:0] START_LOC_OFS = 8'h68;
   localparam logic [7:0] START_R2_OFS = 8'h69;
   // Reset values
   localparam logic [7:0] ACOUSTIC_RST = 8'h00;
   localparam logic [7:0] MIN_DUTY_RST = 8'h80;
   localparam logic [7:0] START_TEMP_RST = 8'h5a;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
   // Acoustics field positions
   localparam int LOC_CODE_LSB = 0;
   localparam int LOC_EN_BIT = 3;
   localparam int R2_CODE_LSB = 4;
   localparam int R2_EN_BIT = 7;
   // Timing
   localparam longint CLK_HZ = 40000000;
   localparam longint FAST_SWEEP_MS = 37500;
   localparam longint SLOW_SWEEP_MS = 52200;
   localparam longint DUTY_STEPS = 256;
   localparam longint FAST_SLOT_CYC = (FAST_SWEEP_MS * (CLK_HZ / 1000)) / DUTY_STEPS;
   localparam longint SLOW_SLOT_CYC = (SLOW_SWEEP_MS * (CLK_HZ / 1000)) / DUTY_STEPS;
   localparam logic [7:0] FULL_DUTY = 8'hff;
   localparam logic [7:0] OFF_DUTY = 8'h00;

   typedef enum logic [2:0] {
      RAMP_ADD1 = 3'b000, RAMP_ADD2 = 3'b001, RAMP_ADD3 = 3'b010, RAMP_ADD4 = 3'b011,
      RAMP_ADD8 = 3'b100, RAMP_ADD12 = 3'b101, RAMP_ADD24 = 3'b110, RAMP_ADD48 = 3'b111
   } ramp_code_e;

   // Per-channel measurement and loop settings
   typedef struct packed {
      logic [7:0] temp;
      logic [2:0] span_log2;
      logic [3:0] hyst;
   } chan_in_s;
endpackage

//--- rtl/duty_ramp.sv
// Purpose: Rate limiter moving a duty value toward a target
// Assumes: slot_tick is a one-cycle pulse per ramp slot
// Notes: With smoothing off the target passes straight through
`timescale 1ns/10ps
module duty_ramp (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic slot_tick_i,
   input wire logic smooth_on_i,
   input wire logic [2:0] code_i,
   input wire logic [7:0] target_i,
   output logic [7:0] duty_o
);
   logic [7:0] step;
   logic [8:0] up_sum;
   logic [8:0] down_dif;

   // Step size from ramp code
   always_comb begin
      case (fan_ctrl_pkg::ramp_code_e'(code_i))
         fan_ctrl_pkg::RAMP_ADD1: step = 8'h01;
         fan_ctrl_pkg::RAMP_ADD2: step = 8'h02;
         fan_ctrl_pkg::RAMP_ADD3: step = 8'h03;
         fan_ctrl_pkg::RAMP_ADD4: step = 8'h04;
         fan_ctrl_pkg::RAMP_ADD8: step = 8'h08;
         fan_ctrl_pkg::RAMP_ADD12: step = 8'h0c;
         fan_ctrl_pkg::RAMP_ADD24: step = 8'h18;
         default: step = 8'h30;
      endcase
   end

   assign up_sum = {1'b0, duty_o} + {1'b0, step};
   assign down_dif = {1'b0, duty_o} - {1'b0, step};

   // Duty update, one step per slot
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         duty_o <= fan_ctrl_pkg::OFF_DUTY;
      end else if (!smooth_on_i) begin
         duty_o <= target_i;
      // [RULE15] clamp at target
      end else if (slot_tick_i) begin
         if (duty_o < target_i) begin
            duty_o <= (up_sum >= {1'b0, target_i}) ? target_i : up_sum[7:0];
         end else if (duty_o > target_i) begin
            duty_o <= (down_dif[8] || down_dif[7:0] <= target_i) ? target_i : down_dif[7:0];
         end
      end
   end
endmodule

//--- rtl/fan_pwm.sv
// Purpose: 8-bit PWM with registered output
// Assumes: Period of 256 clocks
// Notes: Code 0xff gives a constant high
`timescale 1ns/10ps
module fan_pwm (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] duty_i,
   output logic pwm_o
);
   logic [7:0] cnt_r;

   // Free period counter
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // High while count below code
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pwm_o <= 1'b0;
      // [RULE14] linear, full at ff
      end else begin
         pwm_o <= (duty_i == fan_ctrl_pkg::FULL_DUTY) || (cnt_r < duty_i);
      end
   end
endmodule

//--- rtl/fan_ramp_min_duty_ctrl.sv
// Purpose: Ramp smoothing, floor duty and start temperature registers, fan PWM
// Assumes: Temperatures and settings come from logic on CLK_I
// Notes: Output 1 follows remote 1, output 2 local, output 3 remote 2
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module fan_ramp_min_duty_ctrl #(
   parameter longint FAST_SLOT_CYC = fan_ctrl_pkg::FAST_SLOT_CYC,
   parameter longint SLOW_SLOT_CYC = fan_ctrl_pkg::SLOW_SLOT_CYC
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic LOCK_I,
   input wire logic AUTO_MODE_I,
   input wire logic SLOW_TABLE_I,
   input wire logic [2:0] FLOOR_BELOW_START_I,
   input wire fan_ctrl_pkg::chan_in_s REMOTE1_I,
   input wire fan_ctrl_pkg::chan_in_s LOCAL_I,
   input wire fan_ctrl_pkg::chan_in_s REMOTE2_I,
   output logic [2:0] FAN_DRIVE_O,
   output logic [7:0] DUTY1_O,
   output logic [7:0] DUTY2_O,
   output logic [7:0] DUTY3_O
);
   localparam logic [31:0] FAST_LAST = 32'(FAST_SLOT_CYC - 1);
   localparam logic [31:0] SLOW_LAST = 32'(SLOW_SLOT_CYC - 1);

   logic [7:0] acoustic_ramp_ctrl_b_r;
   logic [7:0] min_duty_r [3];
   logic [7:0] start_temp_r [3];
   logic [31:0] slot_cnt_r;
   logic slot_tick_r;
   logic [2:0] running_r;
   logic [7:0] target [3];
   logic [7:0] duty [3];
   logic [2:0] smooth_on;
   logic [2:0] ramp_code [3];
   fan_ctrl_pkg::chan_in_s chan [3];
   logic [7:0] rd_data;
   logic [1:0] wr_idx;
   logic wr_min;
   logic wr_start;

   assign chan[0] = REMOTE1_I;
   assign chan[1] = LOCAL_I;
   assign chan[2] = REMOTE2_I;

   // Write decode for register groups
   always_comb begin
      wr_idx = 2'd0;
      wr_min = 1'b0;
      wr_start = 1'b0;
      case (ADDR_I)
         fan_ctrl_pkg::MIN_DUTY1_OFS: begin
            wr_idx = 2'd0;
            wr_min = 1'b1;
         end
         fan_ctrl_pkg::MIN_DUTY2_OFS: begin
            wr_idx = 2'd1;
            wr_min = 1'b1;
         end
         fan_ctrl_pkg::MIN_DUTY3_OFS: begin
            wr_idx = 2'd2;
            wr_min = 1'b1;
         end
         fan_ctrl_pkg::START_R1_OFS: begin
            wr_idx = 2'd0;
            wr_start = 1'b1;
         end
         fan_ctrl_pkg::START_LOC_OFS: begin
            wr_idx = 2'd1;
            wr_start = 1'b1;
         end
         fan_ctrl_pkg::START_R2_OFS: begin
            wr_idx = 2'd2;
            wr_start = 1'b1;
         end
         default: begin
            wr_idx = 2'd0;
         end
      endcase
   end

   // Acoustics register
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         acoustic_ramp_ctrl_b_r <= fan_ctrl_pkg::ACOUSTIC_RST;
      // [RULE6] lock blocks writes
      end else if (WR_I && !LOCK_I && ADDR_I == fan_ctrl_pkg::ACOUSTIC_OFS) begin
         acoustic_ramp_ctrl_b_r <= WDATA_I;
      end
   end

   // Floor duty registers
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         // [RULE8] reset to half duty
         for (int i = 0; i < 3; i++) begin
            min_duty_r[i] <= fan_ctrl_pkg::MIN_DUTY_RST;
         end
      // [RULE9] read-only in automatic mode
      end else if (WR_I && wr_min && !AUTO_MODE_I) begin
         min_duty_r[wr_idx] <= WDATA_I;
      end
   end

   // Start temperature registers, frozen by lock
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         // [RULE11] reset to 90 C
         for (int i = 0; i < 3; i++) begin
            start_temp_r[i] <= fan_ctrl_pkg::START_TEMP_RST;
         end
      end else if (WR_I && wr_start && !LOCK_I) begin
         start_temp_r[wr_idx] <= WDATA_I;
      end
   end

   // Read mux
   always_comb begin
      case (ADDR_I)
         fan_ctrl_pkg::ACOUSTIC_OFS: rd_data = acoustic_ramp_ctrl_b_r;
         fan_ctrl_pkg::MIN_DUTY1_OFS: rd_data = min_duty_r[0];
         fan_ctrl_pkg::MIN_DUTY2_OFS: rd_data = min_duty_r[1];
         fan_ctrl_pkg::MIN_DUTY3_OFS: rd_data = min_duty_r[2];
         fan_ctrl_pkg::START_R1_OFS: rd_data = start_temp_r[0];
         fan_ctrl_pkg::START_LOC_OFS: rd_data = start_temp_r[1];
         fan_ctrl_pkg::START_R2_OFS: rd_data = start_temp_r[2];
         default: rd_data = fan_ctrl_pkg::UNMAPPED_RD;
      endcase
   end

   // Read data, valid only the cycle after the strobe
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         RDATA_O <= 8'h00;
      end else if (RD_I) begin
         RDATA_O <= rd_data;
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   // Ramp slot timer; slot length picks the table
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         slot_cnt_r <= 32'h0;
         slot_tick_r <= 1'b0;
      // [RULE2] fast slot
      // [RULE3] slow slot
      end else if (slot_cnt_r >= (SLOW_TABLE_I ? SLOW_LAST : FAST_LAST)) begin
         slot_cnt_r <= 32'h0;
         slot_tick_r <= 1'b1;
      end else begin
         slot_cnt_r <= slot_cnt_r + 32'h1;
         slot_tick_r <= 1'b0;
      end
   end

   // Smoothing enables and ramp codes per output
   assign smooth_on[0] = 1'b0;
   assign ramp_code[0] = 3'b000;
   // [RULE4] local enable bit
   assign smooth_on[1] = acoustic_ramp_ctrl_b_r[fan_ctrl_pkg::LOC_EN_BIT];
   // [RULE12] local code bits
   assign ramp_code[1] = acoustic_ramp_ctrl_b_r[fan_ctrl_pkg::LOC_CODE_LSB +: 3];
   // [RULE5] remote 2 enable and code
   assign smooth_on[2] = acoustic_ramp_ctrl_b_r[fan_ctrl_pkg::R2_EN_BIT];
   assign ramp_code[2] = acoustic_ramp_ctrl_b_r[fan_ctrl_pkg::R2_CODE_LSB +: 3];

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_chan
         logic [8:0] hyst_floor;
         logic [7:0] delta;
         logic [16:0] prod;
         logic [16:0] rise;
         logic [17:0] sum;

         assign hyst_floor = {1'b0, start_temp_r[g]} - {5'h00, chan[g].hyst};
         assign delta = chan[g].temp - start_temp_r[g];
         assign prod = delta * (9'h100 - {1'b0, min_duty_r[g]});
         assign rise = prod >> chan[g].span_log2;
         assign sum = {10'h000, min_duty_r[g]} + {1'b0, rise};

         // Running state with hysteresis
         always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
               running_r[g] <= 1'b0;
            end else if (chan[g].temp > start_temp_r[g]) begin
               running_r[g] <= 1'b1;
            end else if (hyst_floor[8] == 1'b0 && chan[g].temp < hyst_floor[7:0]) begin
               running_r[g] <= 1'b0;
            end
         end

         // Target duty for this output
         always_comb begin
            if (!AUTO_MODE_I) begin
               target[g] = min_duty_r[g];
            // [RULE10] floor plus span slope
            end else if (chan[g].temp > start_temp_r[g]) begin
               target[g] = (sum > 18'(fan_ctrl_pkg::FULL_DUTY)) ? fan_ctrl_pkg::FULL_DUTY
                                                               : sum[7:0];
            // [RULE7] floor while in band
            end else if (running_r[g]) begin
               target[g] = min_duty_r[g];
            // [RULE13] off or floor below
            end else begin
               target[g] = FLOOR_BELOW_START_I[g] ? min_duty_r[g] : fan_ctrl_pkg::OFF_DUTY;
            end
         end

         // [RULE1] stepwise ramp
         duty_ramp u_ramp (
            .clk_i(CLK_I),
            .srst_i(SRST_I),
            .slot_tick_i(slot_tick_r),
            .smooth_on_i(smooth_on[g]),
            .code_i(ramp_code[g]),
            .target_i(target[g]),
            .duty_o(duty[g])
         );

         fan_pwm u_pwm (
            .clk_i(CLK_I),
            .srst_i(SRST_I),
            .duty_i(duty[g]),
            .pwm_o(FAN_DRIVE_O[g])
         );
      end
   endgenerate

   // Registered duty observation
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         DUTY1_O <= 8'h00;
         DUTY2_O <= 8'h00;
         DUTY3_O <= 8'h00;
      end else begin
         DUTY1_O <= duty[0];
         DUTY2_O <= duty[1];
         DUTY3_O <= duty[2];
      end
   end
endmodule

//--- bench/fan_ramp_min_duty_ctrl_assertions.sv
// Purpose: Port checker for the fan ramp and floor duty block
// Assumes: Sim slot lengths of at least 8 clocks
// Notes: Shadows the register file from port traffic
`timescale 1ns/10ps
module fan_ramp_min_duty_ctrl_assertions #(
   parameter longint FAST_SLOT_CYC = 8,
   parameter longint SLOW_SLOT_CYC = 12
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic LOCK_I,
   input wire logic AUTO_MODE_I,
   input wire logic SLOW_TABLE_I,
   input wire logic [2:0] FAN_DRIVE_O,
   input wire logic [7:0] DUTY1_O,
   input wire logic [7:0] DUTY2_O
);
   logic [7:0] sh_r [7];
   logic [7:0] rd_exp;
   logic [1:0] up_r;
   logic [15:0] gap_r;
   logic mapped;
   logic refused;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   // Shadow of the register file, honouring refusals
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         sh_r <= '{8'h00, 8'h80, 8'h80, 8'h80, 8'h5a, 8'h5a, 8'h5a};
      end else if (WR_I && mapped && !refused) begin
         sh_r[3'(ADDR_I - 8'h63)] <= WDATA_I;
      end
   end
   // Expected read data and settle counters
   assign mapped = ADDR_I >= 8'h63 && ADDR_I <= 8'h69;
   assign refused = (ADDR_I == 8'h63 || ADDR_I > 8'h66) ? LOCK_I : AUTO_MODE_I;
   assign rd_exp = mapped ? sh_r[3'(ADDR_I - 8'h63)] : 8'h00;
   always_ff @(posedge CLK_I) begin
      up_r <= SRST_I ? 2'h0 : (up_r == 2'h3 ? up_r : up_r + 2'h1);
      if (SRST_I || !$changed(DUTY2_O)) begin
         gap_r <= (gap_r == 16'hffff) ? gap_r : gap_r + 16'h1;
      end else begin
         gap_r <= 16'h0;
      end
   end
   function automatic int stp(input logic [2:0] c);
      return c < 4 ? c + 1 : c == 4 ? 8 : c == 5 ? 12 : c == 6 ? 24 : 48;
   endfunction
   a_acou_lock: assert property (
      RD_I && ADDR_I == 8'h63 |=> RDATA_O == $past(rd_exp))
      else $error("acoustics read mismatch");
   a_floor_regs: assert property (
      RD_I && ADDR_I inside {[8'h64:8'h66]} |=> RDATA_O == $past(rd_exp))
      else $error("floor duty read mismatch");
   a_start_regs: assert property (
      RD_I && ADDR_I inside {[8'h67:8'h69]} |=> RDATA_O == $past(rd_exp))
      else $error("start temperature read mismatch");
   a_unmapped_rd: assert property (RD_I && !mapped |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
      else $error("read data outside read cycle");
   a_out1_direct: assert property (
      up_r == 2'h3 && !$past(AUTO_MODE_I, 2) |-> DUTY1_O == $past(sh_r[1], 2))
      else $error("output 1 not at floor register");
   a_out2_bypass: assert property (
      up_r == 2'h3 && !$past(AUTO_MODE_I, 2) && !$past(sh_r[0][3], 2)
      |-> DUTY2_O == $past(sh_r[2], 2))
      else $error("output 2 smoothed while disabled");
   a_ramp_step: assert property (
      up_r == 2'h3 && $past(sh_r[0][3], 2) |-> (DUTY2_O >= $past(DUTY2_O) ?
      DUTY2_O - $past(DUTY2_O) : $past(DUTY2_O) - DUTY2_O) <= stp($past(sh_r[0][2:0], 2)))
      else $error("ramp step too large");
   a_slot_gap: assert property (
      up_r == 2'h3 && $past(sh_r[0][3], 2) && $changed(DUTY2_O)
      |-> gap_r >= (SLOW_TABLE_I ? SLOW_SLOT_CYC : FAST_SLOT_CYC) - 1)
      else $error("ramp steps closer than one slot");
   a_pwm_full: assert property (
      DUTY1_O == 8'hff && $past(DUTY1_O) == 8'hff |-> FAN_DRIVE_O[0])
      else $error("full duty not constant high");
   a_pwm_off: assert property (
      DUTY1_O == 8'h00 && $past(DUTY1_O) == 8'h00 |-> !FAN_DRIVE_O[0])
      else $error("zero duty output high");
endmodule
bind fan_ramp_min_duty_ctrl fan_ramp_min_duty_ctrl_assertions #(.FAST_SLOT_CYC(FAST_SLOT_CYC),
   .SLOW_SLOT_CYC(SLOW_SLOT_CYC)) chk_i (.CLK_I(CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .LOCK_I(LOCK_I),
   .AUTO_MODE_I(AUTO_MODE_I), .SLOW_TABLE_I(SLOW_TABLE_I), .FAN_DRIVE_O(FAN_DRIVE_O),
   .DUTY1_O(DUTY1_O), .DUTY2_O(DUTY2_O));

//--- bench/fan_load.sv
// Purpose: Three fans that report high time per 256-clock window
// Assumes: Drive is a steady PWM
// Notes: Window is not aligned to the PWM period
`timescale 1ns/10ps
module fan_load (
   input wire logic clk_i,
   input wire logic [2:0] drive_i,
   output logic [2:0][8:0] hi_o
);
   logic [7:0] win_r = 8'h00;
   logic [2:0][8:0] acc_r = '0;
   // Count high clocks, publish once per window
   always @(posedge clk_i) begin
      win_r <= win_r + 8'h1;
      for (int i = 0; i < 3; i++) begin
         acc_r[i] <= win_r == 8'hff ? 9'h0 : acc_r[i] + 9'(drive_i[i]);
         if (win_r == 8'hff) hi_o[i] <= acc_r[i] + 9'(drive_i[i]);
      end
   end
endmodule

//--- bench/fan_ramp_min_duty_ctrl_tb_top.sv
// Purpose: Register, ramp and floor tests for the fan block
// Assumes: Slot lengths shortened to 8 and 12 clocks
// Notes: Fan model measures PWM high time
`timescale 1ns/10ps
module fan_ramp_min_duty_ctrl_tb_top;
   logic CLK_I = 0, SRST_I = 1, WR_I = 0, RD_I = 0, LOCK_I = 0, AUTO_MODE_I = 0, SLOW_TABLE_I = 0;
   logic [7:0] ADDR_I = 0, WDATA_I = 0, RDATA_O, DUTY1_O, DUTY2_O, DUTY3_O, rv;
   logic [2:0] FLOOR_BELOW_START_I = 0, FAN_DRIVE_O;
   fan_ctrl_pkg::chan_in_s REMOTE1_I = '0, LOCAL_I = '0, REMOTE2_I = '0;
   logic [2:0][8:0] hi;
   logic [7:0] tt [6] = '{8'h50, 8'h5a, 8'h5b, 8'h6a, 8'h58, 8'h55};
   logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h81, 8'hff, 8'h80, 8'h00};
   int failures = 0, tests_run = 0;
   always #12.5 CLK_I = ~CLK_I;
   fan_ramp_min_duty_ctrl #(.FAST_SLOT_CYC(8), .SLOW_SLOT_CYC(12)) DUT (.CLK_I(CLK_I),
      .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
      .RDATA_O(RDATA_O), .LOCK_I(LOCK_I), .AUTO_MODE_I(AUTO_MODE_I), .SLOW_TABLE_I(SLOW_TABLE_I),
      .FLOOR_BELOW_START_I(FLOOR_BELOW_START_I), .REMOTE1_I(REMOTE1_I), .LOCAL_I(LOCAL_I),
      .REMOTE2_I(REMOTE2_I), .FAN_DRIVE_O(FAN_DRIVE_O), .DUTY1_O(DUTY1_O), .DUTY2_O(DUTY2_O),
      .DUTY3_O(DUTY3_O));
   fan_load FANS (.clk_i(CLK_I), .drive_i(FAN_DRIVE_O), .hi_o(hi));
   task automatic chk(input logic [8:0] g, e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1;
      @(posedge CLK_I) WR_I <= 0;
      @(posedge CLK_I);
   endtask
   task automatic rdc(input logic [7:0] a, e);
      ADDR_I <= a;
      RD_I <= 1;
      @(posedge CLK_I) RD_I <= 0;
      #1 chk(RDATA_O, e);
      @(posedge CLK_I);
   endtask
   // Follow one ramp, predicting each step from the code's step size
   task automatic ramp(input int ch, input logic [7:0] e, t, input int s);
      logic [7:0] p;
      int n;
      while (e !== t) begin
         p = e;
         e = e > t ? (e - t > s ? e - 8'(s) : t) : (t - e > s ? e + 8'(s) : t);
         n = 0;
         while ((ch == 2 ? DUTY2_O : DUTY3_O) === p && n < 40) begin
            @(negedge CLK_I);
            n++;
         end
         chk(ch == 2 ? DUTY2_O : DUTY3_O, e);
      end
      @(posedge CLK_I);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge CLK_I);
      failures++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge CLK_I);
      SRST_I <= 0;
      for (int i = 0; i < 7; i++) begin
         rv = i == 0 ? 8'h00 : i < 4 ? 8'h80 : 8'h5a;
         rdc(8'h63 + 8'(i), rv);
         wr(8'h63 + 8'(i), 8'h21 + 8'(i));
         rdc(8'h63 + 8'(i), 8'h21 + 8'(i));
         wr(8'h63 + 8'(i), rv);
      end
      rdc(8'h62, 8'h00);
      rdc(8'h6a, 8'h00);
      $display("test registers done");
      LOCK_I <= 1;
      AUTO_MODE_I <= 1;
      wr(8'h63, 8'hff);
      wr(8'h67, 8'h00);
      wr(8'h64, 8'h11);
      rdc(8'h63, 8'h00);
      rdc(8'h67, 8'h5a);
      rdc(8'h64, 8'h80);
      LOCK_I <= 0;
      AUTO_MODE_I <= 0;
      $display("test refusals done");
      for (int i = 0; i < 3; i++) begin
         rv = i == 0 ? 8'hff : i == 1 ? 8'h40 : 8'h00;
         wr(8'h64, rv);
         repeat (600) @(posedge CLK_I);
         chk(DUTY1_O, rv);
         chk(hi[0], rv == 8'hff ? 9'h100 : {1'b0, rv});
         chk(hi[1], 9'h080);
         chk(hi[2], 9'h080);
      end
      wr(8'h64, 8'h80);
      $display("test floor duty done");
      wr(8'h63, 8'h0f);
      wr(8'h65, 8'h10);
      ramp(2, 8'h80, 8'h10, 48);
      SLOW_TABLE_I <= 1;
      wr(8'h63, 8'h0b);
      wr(8'h65, 8'h18);
      ramp(2, 8'h10, 8'h18, 4);
      wr(8'h63, 8'hd0);
      wr(8'h65, 8'h40);
      repeat (4) @(posedge CLK_I);
      chk(DUTY2_O, 8'h40);
      wr(8'h66, 8'h60);
      ramp(3, 8'h80, 8'h60, 12);
      wr(8'h63, 8'h00);
      SLOW_TABLE_I <= 0;
      $display("test ramp done");
      AUTO_MODE_I <= 1;
      for (int i = 0; i < 6; i++) begin
         REMOTE1_I <= '{temp: tt[i], span_log2: i < 3 ? 3'h7 : 3'h4, hyst: 4'h4};
         repeat (6) @(posedge CLK_I);
         chk(DUTY1_O, ex[i]);
      end
      FLOOR_BELOW_START_I <= 3'b001;
      repeat (6) @(posedge CLK_I);
      chk(DUTY1_O, 8'h80);
      $display("test automatic loop done");
      stop_test();
   end
endmodule
